/* File: design/scr_regs.sv */
// sensor control register bank: serial port, control registers, sampling, filter and i/o lines
`timescale 1ns/1ps

//Behaviour
//[R01] period at or above threshold: low power
//[R02] indefinite sleep until select edge or reset
//[R03] timed sleep in half-second units
//[R04] two cascaded averagers of 2^M taps
//[R05] range field selects 300/150/75 deg/s
//[R06] low ranges force minimum tap field
//[R07] host writes range before taps
//[R08] gpio low nibble sets line direction
//[R09] gpio high nibble sets line levels
//[R10] line priority: misc, alarm, gpio
//[R11] line 4 input, period zero: external clock
//[R12] misc bits enable, polarity, line of ready
//[R13] ready pulse 100 to 200 us
//[R14] memory test bit self-clears when done
//[R15] self-test bit self-clears when done
//[R16] bits 9/8 apply negative/positive stimulus
//[R17] bits 7/6 enable bias comp, alignment
//[R18] converter register holds 12-bit code
//[R19] latch copies both bytes at once
//[R20] host writes low, high, then latches
//[R21] command trigger bits return to zero
//[R22] write frame: one, address, byte
module scr_regs
  import scr_pkg::*;
#(
  parameter int TB0_CYCLES       = TB0_CYC,
  parameter int TB1_CYCLES       = TB1_CYC,
  parameter int SLEEP_UNIT_CYC   = SLEEP_CYC,
  parameter int DR_PULSE_CYCLES  = DR_CYC,
  parameter int SELF_TEST_CYCLES = SELFTEST_CYC,
  parameter int MEM_TEST_CYCLES  = MEMTEST_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_din,
  output logic             spi_dout,
  output logic             spi_dout_oe,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  input  wire logic [3:0]  alarm_claim,
  input  wire logic [3:0]  alarm_level,
  input  wire logic [15:0] sensor_data,
  output logic      [15:0] filtered_data,
  output logic             sample_strobe,
  output logic             low_power,
  output logic             sleeping,
  output logic      [2:0]  gyro_range,
  output logic             self_test_run,
  output logic             mem_test_run,
  output logic             stim_neg,
  output logic             stim_pos,
  output logic             bias_comp_en,
  output logic             origin_align_en,
  output logic      [11:0] dac_code
);

  // ***********************************************************************
  // reset release
  // ***********************************************************************
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  scr_state_t s;
  scr_state_t next_s;

  // ***********************************************************************
  // helpers
  // ***********************************************************************
  function automatic logic [2:0] scr_clamp(input logic [2:0] taps, input logic [2:0] rng);
    logic [2:0] t;
    t = taps;
    if (rng == RANGE_150 && t < TAPS_MIN150) begin // [R06]
      t = TAPS_MIN150;
    end else if (rng == RANGE_75 && t < TAPS_MIN75) begin // [R06]
      t = TAPS_MIN75;
    end
    return t;
  endfunction

  function automatic logic [15:0] scr_read(input scr_state_t st, input logic [6:0] addr);
    logic [6:0]  a;
    logic [15:0] w;
    logic [3:0]  lvl;
    a   = {addr[6:1], 1'b0};
    w   = 16'h0000;
    lvl = 4'h0;
    for (int i = 0; i < 4; i++) begin
      lvl[i] = st.gpio[i] ? st.gpio[GPIO_DATA + i] : st.io_sync[i];
    end
    if (a == ADDR_AUX) begin
      w = st.aux;
    end else if (a == ADDR_GPIO) begin
      w = {4'h0, lvl, 4'h0, st.gpio[3:0]};
    end else if (a == ADDR_MSC) begin
      w = st.misc;
    end else if (a == ADDR_SMPL) begin
      w = st.smpl;
    end else if (a == ADDR_AVG) begin
      w = st.avg;
    end else if (a == ADDR_SLP) begin
      w = st.slp;
    end
    return w;
  endfunction

  // ***********************************************************************
  // next state
  // ***********************************************************************
  always_comb begin
    logic        rise;
    logic        fall;
    logic        cs_fall;
    logic        wr;
    logic [6:0]  wa;
    logic [7:0]  wd;
    logic        tick;
    logic        ext_mode;
    logic [31:0] tb_len;
    logic [2:0]  m;
    logic [6:0]  step;
    logic [15:0] x;
    logic [15:0] old;
    logic [22:0] nsum;
    logic        dr_level;
    logic [2:0]  rng;
    rise     = 1'b0;
    fall     = 1'b0;
    cs_fall  = 1'b0;
    wr       = 1'b0;
    wa       = 7'h00;
    wd       = 8'h00;
    tick     = 1'b0;
    ext_mode = 1'b0;
    tb_len   = 32'h0;
    m        = 3'h0;
    step     = 7'h00;
    x        = 16'h0000;
    old      = 16'h0000;
    nsum     = 23'h0;
    dr_level = 1'b0;
    rng      = 3'h0;
    next_s   = s;

    // pins cross two flops; edges are found on the second stage only
    next_s.sclk_meta = spi_sclk;
    next_s.sclk_sync = s.sclk_meta;
    next_s.sclk_prev = s.sclk_sync;
    next_s.cs_meta   = spi_cs_n;
    next_s.cs_sync   = s.cs_meta;
    next_s.cs_prev   = s.cs_sync;
    next_s.din_meta  = spi_din;
    next_s.din_sync  = s.din_meta;
    next_s.io_meta   = io_in;
    next_s.io_sync   = s.io_meta;
    next_s.io4_prev  = s.io_sync[EXT_CLK_LINE];
    rise    = s.sclk_sync & ~s.sclk_prev;
    fall    = ~s.sclk_sync & s.sclk_prev;
    cs_fall = ~s.cs_sync & s.cs_prev;

    // ***********************************************************************
    // serial frame: shift in on rising edge, launch out on falling edge
    // ***********************************************************************
    if (cs_fall) begin
      next_s.tx    = scr_read(s, s.rd_addr);
      next_s.nbits = 5'h00;
    end else if (!s.cs_sync) begin
      if (fall) begin
        next_s.dout = s.tx[15];
        next_s.tx   = {s.tx[14:0], 1'b0};
      end
      if (rise && s.nbits != FRAME_BITS) begin
        next_s.rx    = {s.rx[14:0], s.din_sync};
        next_s.nbits = s.nbits + 5'h01;
        if (s.nbits == FRAME_BITS - 5'h01) begin
          if (next_s.rx[CMD_WRITE]) begin // [R22]
            wr = 1'b1;
            wa = next_s.rx[14:8];
            wd = next_s.rx[7:0];
          end else begin
            next_s.rd_addr = next_s.rx[14:8];
          end
        end
      end
    end

    // ***********************************************************************
    // sample timing
    // ***********************************************************************
    ext_mode = ~s.gpio[EXT_CLK_LINE] && s.smpl[7:0] == EXT_CLK_PRD; // [R11]
    tb_len   = s.smpl[SMPL_TB] ? 32'(TB1_CYCLES) : 32'(TB0_CYCLES);
    if (!s.asleep) begin
      if (ext_mode) begin
        tick = s.io_sync[EXT_CLK_LINE] & ~s.io4_prev; // [R11]
      end else if (s.tb_cnt >= tb_len - 32'h1) begin
        next_s.tb_cnt = 32'h0;
        if (s.prd_cnt >= s.smpl[6:0]) begin
          next_s.prd_cnt = 7'h00;
          tick           = 1'b1;
        end else begin
          next_s.prd_cnt = s.prd_cnt + 7'h01;
        end
      end else begin
        next_s.tb_cnt = s.tb_cnt + 32'h1;
      end
    end
    next_s.tick = tick;

    // ***********************************************************************
    // two cascaded moving averages, each 2^M deep
    // ***********************************************************************
    m    = s.avg[2:0];
    step = 7'(8'h01 << m);
    if (tick) begin
      x = sensor_data;
      for (int k = 0; k < 2; k++) begin
        old              = s.hist[k][s.wptr - step];
        nsum             = s.sum[k] + {{7{x[15]}}, x} - {{7{old[15]}}, old}; // [R04]
        next_s.sum[k]    = nsum;
        next_s.hist[k][s.wptr] = x;
        x                = 16'($signed(nsum) >>> m); // [R04]
      end
      next_s.filt = x;
      next_s.wptr = s.wptr + 7'h01;
    end

    // ***********************************************************************
    // data ready pulse
    // ***********************************************************************
    if (tick) begin
      next_s.dr_act = 1'b1;
      next_s.dr_cnt = 32'h0;
    end else if (s.dr_act) begin
      if (s.dr_cnt >= 32'(DR_PULSE_CYCLES) - 32'h1) begin // [R13]
        next_s.dr_act = 1'b0;
      end else begin
        next_s.dr_cnt = s.dr_cnt + 32'h1;
      end
    end

    // ***********************************************************************
    // self-clearing tests and sleep timing
    // ***********************************************************************
    if (s.misc[MSC_SELFTEST]) begin
      next_s.st_cnt = s.st_cnt + 32'h1;
      if (s.st_cnt >= 32'(SELF_TEST_CYCLES) - 32'h1) begin
        next_s.misc[MSC_SELFTEST] = 1'b0; // [R15]
      end
    end
    if (s.misc[MSC_MEMTEST]) begin
      next_s.mt_cnt = s.mt_cnt + 32'h1;
      if (s.mt_cnt >= 32'(MEM_TEST_CYCLES) - 32'h1) begin
        next_s.misc[MSC_MEMTEST] = 1'b0; // [R14]
      end
    end
    if (s.asleep) begin
      if (s.slp[SLP_INDEF]) begin
        if (cs_fall) begin // [R02]
          next_s.asleep         = 1'b0;
          next_s.slp[SLP_INDEF] = 1'b0;
        end
      end else if (s.half_cnt >= 32'(SLEEP_UNIT_CYC) - 32'h1) begin
        next_s.half_cnt = 32'h0;
        if (s.sleep_left <= 8'h01) begin // [R03]
          next_s.asleep     = 1'b0;
          next_s.sleep_left = 8'h00;
          next_s.slp[7:0]   = 8'h00;
        end else begin
          next_s.sleep_left = s.sleep_left - 8'h01;
        end
      end else begin
        next_s.half_cnt = s.half_cnt + 32'h1;
      end
    end

    // ***********************************************************************
    // register writes; a write lands after self-clear so a new start wins
    // ***********************************************************************
    if (wr) begin
      if (wa == ADDR_AUX) begin
        next_s.aux[7:0] = wd; // [R18]
      end else if (wa == (ADDR_AUX | 7'h01)) begin
        next_s.aux[15:8] = wd & NIBBLE_MASK; // [R18]
      end else if (wa == ADDR_GPIO) begin
        next_s.gpio[7:0] = wd & NIBBLE_MASK; // [R08]
      end else if (wa == (ADDR_GPIO | 7'h01)) begin
        next_s.gpio[15:8] = wd & NIBBLE_MASK; // [R09]
      end else if (wa == ADDR_MSC) begin
        next_s.misc[7:0] = wd & MSC_LO_MASK; // [R12] [R17]
      end else if (wa == (ADDR_MSC | 7'h01)) begin
        next_s.misc[15:8] = (wd & NIBBLE_MASK) | (s.misc[15:8] & next_s.misc[15:8] & 8'h0c);
        if (wd[HI_SELFTEST]) begin
          next_s.st_cnt = 32'h0; // [R15]
        end
        if (wd[HI_MEMTEST]) begin
          next_s.mt_cnt = 32'h0; // [R14]
        end
      end else if (wa == ADDR_SMPL) begin
        next_s.smpl[7:0] = wd;
      end else if (wa == ADDR_AVG) begin
        next_s.avg[2:0] = scr_clamp(wd[2:0], s.avg[10:8]); // [R06]
        next_s.hist     = '0;
        next_s.sum      = '0;
      end else if (wa == (ADDR_AVG | 7'h01)) begin
        rng = wd[2:0];
        if (rng == RANGE_300 || rng == RANGE_150 || rng == RANGE_75) begin // [R05]
          next_s.avg[10:8] = rng;
          // a narrower range may raise the taps already set
          next_s.avg[2:0]  = scr_clamp(s.avg[2:0], rng); // [R06] [R07]
          next_s.hist      = '0;
          next_s.sum       = '0;
        end
      end else if (wa == ADDR_SLP) begin
        next_s.slp[7:0] = wd;
        if (wd != 8'h00) begin // [R03]
          next_s.asleep     = 1'b1;
          next_s.sleep_left = wd;
          next_s.half_cnt   = 32'h0;
        end
      end else if (wa == (ADDR_SLP | 7'h01)) begin
        if (wd[SLP_INDEF - 8]) begin // [R02]
          next_s.slp[SLP_INDEF] = 1'b1;
          next_s.asleep         = 1'b1;
        end
      end else if (wa == ADDR_GLOB) begin
        if (wd[GLOB_LATCH]) begin
          // both bytes move together; the trigger completes in this cycle
          next_s.dac = s.aux[11:0]; // [R19] [R20] [R21]
        end
      end
    end

    // ***********************************************************************
    // i/o line resolution, registered so the pins never glitch
    // ***********************************************************************
    dr_level = s.misc[MSC_DR_POL] ? s.dr_act : ~s.dr_act; // [R12]
    for (int i = 0; i < 4; i++) begin
      if (s.misc[MSC_DR_EN] && i == int'(s.misc[MSC_DR_LINE])) begin // [R10] [R12]
        next_s.io_out[i] = dr_level;
        next_s.io_oe[i]  = 1'b1;
      end else if (alarm_claim[i]) begin // [R10]
        next_s.io_out[i] = alarm_level[i];
        next_s.io_oe[i]  = 1'b1;
      end else begin
        next_s.io_out[i] = s.gpio[GPIO_DATA + i]; // [R09]
        next_s.io_oe[i]  = s.gpio[i]; // [R08]
      end
    end
  end

  // ***********************************************************************
  // state register
  // ***********************************************************************
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s           <= '0;
      s.sclk_meta <= 1'b1;
      s.sclk_sync <= 1'b1;
      s.sclk_prev <= 1'b1;
      s.cs_meta   <= 1'b1;
      s.cs_sync   <= 1'b1;
      s.cs_prev   <= 1'b1;
      s.aux       <= AUX_RST;
      s.gpio      <= GPIO_RST;
      s.misc      <= MSC_RST;
      s.smpl      <= SMPL_RST;
      s.avg       <= AVG_RST;
      s.slp       <= SLP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign spi_dout        = s.dout;
  assign spi_dout_oe     = ~s.cs_sync;
  assign io_out          = s.io_out;
  assign io_oe           = s.io_oe;
  assign filtered_data   = s.filt;
  assign sample_strobe   = s.tick;
  assign low_power       = s.smpl[7:0] >= LOW_POWER_PRD; // [R01]
  assign sleeping        = s.asleep;
  assign gyro_range      = s.avg[10:8]; // [R05]
  assign self_test_run   = s.misc[MSC_SELFTEST];
  assign mem_test_run    = s.misc[MSC_MEMTEST];
  assign stim_neg        = s.misc[MSC_ST_NEG]; // [R16]
  assign stim_pos        = s.misc[MSC_ST_POS]; // [R16]
  assign bias_comp_en    = s.misc[MSC_BIAS]; // [R17]
  assign origin_align_en = s.misc[MSC_ORIGIN]; // [R17]
  assign dac_code        = s.dac;

endmodule // scr_regs

/* File: design/scr_pkg.sv */
// constants, register map and state type of the sensor control register bank
package scr_pkg;

  // ***********************************************************************
  // register map: byte addresses, low byte even, high byte at +1
  // ***********************************************************************
  localparam logic [6:0] ADDR_AUX  = 7'h30;
  localparam logic [6:0] ADDR_GPIO = 7'h32;
  localparam logic [6:0] ADDR_MSC  = 7'h34;
  localparam logic [6:0] ADDR_SMPL = 7'h36;
  localparam logic [6:0] ADDR_AVG  = 7'h38;
  localparam logic [6:0] ADDR_SLP  = 7'h3a;
  localparam logic [6:0] ADDR_GLOB = 7'h3e;

  localparam logic [15:0] AUX_RST  = 16'h0000;
  localparam logic [15:0] GPIO_RST = 16'h0000;
  localparam logic [15:0] MSC_RST  = 16'h0006;
  localparam logic [15:0] SMPL_RST = 16'h0001;
  localparam logic [15:0] AVG_RST  = 16'h0402;
  localparam logic [15:0] SLP_RST  = 16'h0000;

  localparam logic [7:0] NIBBLE_MASK = 8'h0f;
  localparam logic [7:0] MSC_LO_MASK = 8'hc7;

  // ***********************************************************************
  // field positions
  // ***********************************************************************
  localparam int MSC_DR_LINE  = 0;
  localparam int MSC_DR_POL   = 1;
  localparam int MSC_DR_EN    = 2;
  localparam int MSC_ORIGIN   = 6;
  localparam int MSC_BIAS     = 7;
  localparam int MSC_ST_POS   = 8;
  localparam int MSC_ST_NEG   = 9;
  localparam int MSC_SELFTEST = 10;
  localparam int MSC_MEMTEST  = 11;
  localparam int HI_SELFTEST  = 2;
  localparam int HI_MEMTEST   = 3;
  localparam int SLP_INDEF    = 8;
  localparam int GLOB_LATCH   = 2;
  localparam int SMPL_TB      = 7;
  localparam int CMD_WRITE    = 15;
  localparam int EXT_CLK_LINE = 3;
  localparam int GPIO_DATA    = 8;

  localparam logic [2:0] RANGE_300   = 3'h4;
  localparam logic [2:0] RANGE_150   = 3'h2;
  localparam logic [2:0] RANGE_75    = 3'h1;
  localparam logic [2:0] TAPS_MIN150 = 3'h2;
  localparam logic [2:0] TAPS_MIN75  = 3'h4;

  localparam logic [7:0] LOW_POWER_PRD = 8'h0a;
  localparam logic [7:0] EXT_CLK_PRD   = 8'h00;
  localparam logic [4:0] FRAME_BITS    = 5'h10;

  // ***********************************************************************
  // timing
  // ***********************************************************************
  localparam real CLK_MHZ      = 125.0;
  localparam real TB0_MS       = 0.61035;
  localparam real TB1_MS       = 18.921;
  localparam real SLEEP_UNIT_S = 0.5;
  localparam real DR_MIN_US    = 100.0;
  localparam int  TB0_CYC      = int'(TB0_MS * 1.0e3 * CLK_MHZ);
  localparam int  TB1_CYC      = int'(TB1_MS * 1.0e3 * CLK_MHZ);
  localparam int  SLEEP_CYC    = int'(SLEEP_UNIT_S * 1.0e6 * CLK_MHZ);
  localparam int  DR_CYC       = int'($ceil(DR_MIN_US * CLK_MHZ));
  localparam int  SELFTEST_CYC = 1000;
  localparam int  MEMTEST_CYC  = 1000;

  typedef struct packed {
    logic                    sclk_meta;
    logic                    sclk_sync;
    logic                    sclk_prev;
    logic                    cs_meta;
    logic                    cs_sync;
    logic                    cs_prev;
    logic                    din_meta;
    logic                    din_sync;
    logic [3:0]              io_meta;
    logic [3:0]              io_sync;
    logic                    io4_prev;
    logic [15:0]             rx;
    logic [15:0]             tx;
    logic [4:0]              nbits;
    logic [6:0]              rd_addr;
    logic                    dout;
    logic [15:0]             aux;
    logic [15:0]             gpio;
    logic [15:0]             misc;
    logic [15:0]             smpl;
    logic [15:0]             avg;
    logic [15:0]             slp;
    logic [11:0]             dac;
    logic [31:0]             tb_cnt;
    logic [6:0]              prd_cnt;
    logic                    tick;
    logic                    asleep;
    logic [7:0]              sleep_left;
    logic [31:0]             half_cnt;
    logic [31:0]             st_cnt;
    logic [31:0]             mt_cnt;
    logic [31:0]             dr_cnt;
    logic                    dr_act;
    logic [3:0]              io_out;
    logic [3:0]              io_oe;
    logic [6:0]              wptr;
    logic [1:0][127:0][15:0] hist;
    logic [1:0][22:0]        sum;
    logic [15:0]             filt;
  } scr_state_t;

endpackage

/* File: verification/scr_regs_properties.sv */
// assertion checker bound to the sensor control register bank
`timescale 1ns/1ps
module scr_regs_checker #(
  parameter int DR_PULSE_CYCLES  = 12500,
  parameter int SELF_TEST_CYCLES = 1000,
  parameter int MEM_TEST_CYCLES  = 1000
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        spi_cs_n,
  input wire logic [3:0]  io_out,
  input wire logic [3:0]  io_oe,
  input wire logic [3:0]  alarm_claim,
  input wire logic [3:0]  alarm_level,
  input wire logic        sample_strobe,
  input wire logic        low_power,
  input wire logic        sleeping,
  input wire logic [2:0]  gyro_range,
  input wire logic        self_test_run,
  input wire logic        mem_test_run,
  input wire logic [11:0] dac_code
);
  logic [31:0] dr_len;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dr_len <= 32'h0;
    end else begin
      dr_len <= (io_out[0] && io_oe[0]) ? dr_len + 32'h1 : 32'h0;
    end
  end
  property p_dr_follows; sample_strobe |=> io_out[0] && io_oe[0]; endproperty
  a_dr_follows: assert property (p_dr_follows) else $error("ready not raised");
  property p_dr_width; $fell(io_out[0]) && io_oe[0] |-> dr_len == DR_PULSE_CYCLES; endproperty
  a_dr_width: assert property (p_dr_width) else $error("ready pulse width wrong");
  property p_st_clear; $rose(self_test_run) |-> ##[1:SELF_TEST_CYCLES] !self_test_run; endproperty
  a_st_clear: assert property (p_st_clear) else $error("self test stuck");
  property p_mt_clear; $rose(mem_test_run) |-> ##[1:MEM_TEST_CYCLES] !mem_test_run; endproperty
  a_mt_clear: assert property (p_mt_clear) else $error("memory test stuck");
  property p_sleep_quiet; sleeping && $past(sleeping) |-> !sample_strobe; endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sample taken while asleep");
  property p_wake_cs; sleeping && $fell(spi_cs_n) |-> ##[1:8] !sleeping; endproperty
  a_wake_cs: assert property (p_wake_cs) else $error("select edge did not wake");
  property p_range_ok; gyro_range inside {3'h4, 3'h2, 3'h1}; endproperty
  a_range_ok: assert property (p_range_ok) else $error("illegal range pattern");
  property p_alarm_wins; alarm_claim[2] |=> io_oe[2] && io_out[2] == $past(alarm_level[2]); endproperty
  a_alarm_wins: assert property (p_alarm_wins) else $error("alarm claim lost");
  property p_dac_cmd; $changed(dac_code) |-> !spi_cs_n; endproperty
  a_dac_cmd: assert property (p_dac_cmd) else $error("dac moved outside command");
  property p_lp_cmd; $changed(low_power) |-> !spi_cs_n; endproperty
  a_lp_cmd: assert property (p_lp_cmd) else $error("low power changed outside a command");
  c_sleep: cover property (sleeping ##1 !sleeping);
  c_self_test: cover property ($fell(self_test_run));
  c_dac: cover property ($changed(dac_code));
endmodule // scr_regs_checker
bind scr_regs scr_regs_checker #(.DR_PULSE_CYCLES(DR_PULSE_CYCLES), .SELF_TEST_CYCLES(SELF_TEST_CYCLES),
  .MEM_TEST_CYCLES(MEM_TEST_CYCLES)) chk_u (.mclk, .rst_n, .spi_cs_n, .io_out, .io_oe, .alarm_claim,
  .alarm_level, .sample_strobe, .low_power, .sleeping, .gyro_range, .self_test_run, .mem_test_run, .dac_code);

/* File: verification/scr_host_model.sv */
// serial host model: mode 3 frames of sixteen bits
`timescale 1ns/1ps
module scr_host_model (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_din,
  input  wire logic spi_dout
);
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_din  = 1'b1;
  end
  // link clock runs only inside a frame; 125 ns period, no phase tie to mclk
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rd);
    rd = 16'h0000;
    spi_cs_n = 1'b0;
    #250;
    for (int i = 15; i >= 0; i--) begin
      spi_sclk = 1'b0;
      spi_din = cmd[i];
      #62.5;
      spi_sclk = 1'b1;
      rd = {rd[14:0], spi_dout};
      #62.5;
    end
    #125;
    spi_cs_n = 1'b1;
    spi_din = ~spi_din;
    #250;
  endtask
endmodule // scr_host_model

/* File: verification/tb_top.sv */
// self-checking testbench of the sensor control register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import scr_pkg::*;
  logic        mclk, rst_n, spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe;
  logic [3:0]  io_in, io_out, io_oe, io_drv, alarm_claim, alarm_level;
  logic [15:0] sensor_data, filtered_data;
  logic        sample_strobe, low_power, sleeping, self_test_run, mem_test_run;
  logic        stim_neg, stim_pos, bias_comp_en, origin_align_en;
  logic [2:0]  gyro_range;
  logic [11:0] dac_code;
  logic        st_seen = 1'b0, mt_seen = 1'b0;
  int          fails = 0;
  int          total_checks = 0;
  assign io_in = (io_oe & io_out) | (~io_oe & io_drv);
  scr_regs #(.TB0_CYCLES(20), .SLEEP_UNIT_CYC(50), .DR_PULSE_CYCLES(5),
    .SELF_TEST_CYCLES(10), .MEM_TEST_CYCLES(10)) dut_u (.mclk, .rst_n, .spi_sclk, .spi_cs_n, .spi_din,
    .spi_dout, .spi_dout_oe, .io_in, .io_out, .io_oe, .alarm_claim, .alarm_level, .sensor_data,
    .filtered_data, .sample_strobe, .low_power, .sleeping, .gyro_range, .self_test_run, .mem_test_run,
    .stim_neg, .stim_pos, .bias_comp_en, .origin_align_en, .dac_code);
  scr_host_model host_u (.spi_sclk, .spi_cs_n, .spi_din, .spi_dout);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (self_test_run === 1'b1) st_seen = 1'b1;
    if (mem_test_run === 1'b1) mt_seen = 1'b1;
  end
  task automatic test_done();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host_u.xfer({1'b1, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    host_u.xfer({1'b0, a, 8'h00}, v);
    host_u.xfer(16'h0000, v);
  endtask
  task automatic wait_strobe();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (sample_strobe !== 1'b1 && n < 400);
    if (n >= 400) begin
      fails++;
      test_done();
    end
  endtask
  task automatic t_reset();
    logic [15:0] v;
    logic [6:0]  a [6] = '{ADDR_AUX, ADDR_GPIO, ADDR_MSC, ADDR_SMPL, ADDR_AVG, 7'h10};
    logic [15:0] e [6] = '{16'h0000, 16'h0000, 16'h0006, 16'h0001, 16'h0402, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], v);
      `CHK("reset value", e[i], v)
    end
    `CHK("reset range", 3'h4, gyro_range)
    `CHK("ready line driven", 1'b1, io_oe[0])
  endtask
  task automatic t_range();
    logic [15:0] v;
    wr(7'h39, 8'h02);
    `CHK("range 150", 3'h2, gyro_range)
    wr(ADDR_AVG, 8'h00);
    rd(ADDR_AVG, v);
    `CHK("taps at 150", 16'h0202, v)
    wr(7'h39, 8'h01);
    rd(ADDR_AVG, v);
    `CHK("taps at 75", 16'h0104, v)
    wr(7'h39, 8'h03);
    `CHK("bad pattern", 3'h1, gyro_range)
    wr(7'h39, 8'h04);
    wr(ADDR_AVG, 8'h01);
    `CHK("range 300", 3'h4, gyro_range)
  endtask
  task automatic t_filter();
    repeat (6) wait_strobe();
    sensor_data = 16'h00c0;
    wait_strobe();
    `CHK("filter step 1", 16'h0060, filtered_data)
    wait_strobe();
    `CHK("filter step 2", 16'h00a0, filtered_data)
  endtask
  task automatic t_gpio();
    wr(7'h33, 8'h08);
    wr(ADDR_GPIO, 8'h0c);
    `CHK("directions", 4'hd, io_oe)
    `CHK("levels", 2'h2, io_out[3:2])
    alarm_claim = 4'h4;
    alarm_level = 4'h4;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("alarm over gpio", 1'b1, io_out[2])
    alarm_claim = 4'h0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("gpio back", 1'b0, io_out[2])
  endtask
  task automatic t_misc();
    logic [15:0] v;
    wr(ADDR_MSC, 8'h86);
    wr(7'h35, 8'h02);
    `CHK("stimulus", 2'h2, {stim_neg, stim_pos})
    `CHK("compensation", 2'h2, {bias_comp_en, origin_align_en})
    wr(7'h35, 8'h04);
    wr(7'h35, 8'h08);
    rd(ADDR_MSC, v);
    `CHK("tests ran", 2'h3, {st_seen, mt_seen})
    `CHK("test bits cleared", 16'h0086, v)
  endtask
  task automatic t_dac();
    logic [15:0] v;
    wr(ADDR_AUX, 8'hd9);
    wr(7'h31, 8'h04);
    `CHK("dac held", 12'h000, dac_code)
    wr(ADDR_GLOB, 8'h04);
    `CHK("dac latched", 12'h4d9, dac_code)
    rd(ADDR_GLOB, v);
    `CHK("latch bit", 16'h0000, v)
  endtask
  task automatic t_power();
    int cnt;
    cnt = 0;
    wr(ADDR_SMPL, 8'h09);
    `CHK("below threshold", 1'b0, low_power)
    wr(ADDR_SMPL, 8'h0a);
    `CHK("at threshold", 1'b1, low_power)
    wr(ADDR_GPIO, 8'h04);
    wr(ADDR_SMPL, 8'h00);
    for (int i = 0; i < 600; i++) begin
      @(posedge mclk);
      #1;
      io_drv[3] = (i % 200) < 100;
      if (sample_strobe === 1'b1) cnt++;
    end
    `CHK("external samples", 3, cnt)
    io_drv[3] = 1'b0;
    wr(ADDR_SMPL, 8'h01);
  endtask
  task automatic t_sleep();
    int n;
    logic [15:0] v;
    n = 0;
    wr(ADDR_SLP, 8'h03);
    `CHK("timed sleep", 1'b1, sleeping)
    while (sleeping === 1'b1 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK("sleep length", 1'b1, n >= 90 && n <= 110)
    wr(7'h3b, 8'h01);
    repeat (300) @(posedge mclk);
    #1;
    `CHK("indefinite sleep", 1'b1, sleeping)
    rd(ADDR_SLP, v);
    `CHK("woken by select", 1'b0, sleeping)
    `CHK("sleep bits", 16'h0000, v)
  endtask
  initial begin
    rst_n = 1'b0;
    io_drv = 4'h0;
    alarm_claim = 4'h0;
    alarm_level = 4'h0;
    sensor_data = 16'h0040;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    t_reset();
    t_range();
    t_filter();
    t_gpio();
    t_misc();
    t_dac();
    t_power();
    t_sleep();
    test_done();
  end
endmodule // tb_top
